// ### close_timing_pkg.sv
// Shared constants, types and delay helpers for the bank close link
package close_timing_pkg;

  typedef logic [7:0] cnt_t;

  // Command opcodes carried on the first command cycle
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ACT = 3'h1,
    OP_RD = 3'h2,
    OP_WR = 3'h3,
    OP_MWR = 3'h4,
    OP_PRE = 3'h5
  } cmd_op_t;

  // ==========================================================
  // Link field positions
  localparam int FLAG_BIT = 5;
  localparam int OP_LSB = 0;
  localparam int BANK_LSB = 0;
  localparam int NUM_BANKS = 8;

  // ==========================================================
  // Timing, in picoseconds as printed, and derived cycle counts
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ALL_BANK_CLOSE_TIME_PS = 21000;
  localparam int SINGLE_BANK_CLOSE_TIME_PS = 18000;
  localparam int ROW_ACTIVE_MIN_TIME_PS = 42000;
  localparam int READ_TO_CLOSE_TIME_PS = 7500;
  localparam int WRITE_RECOVERY_TIME_PS = 18000;
  localparam int ACTIVATE_TO_COLUMN_DELAY_PS = 18000;
  localparam int ROW_CYCLE_TIME_PS = 60000;

  // Least times round up, never below one cycle
  function automatic cnt_t ps_to_cycles(int t);
    int c;
    c = (t + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1) c = 1;
    return cnt_t'(c);
  endfunction

  localparam cnt_t ALL_BANK_CLOSE_CYC = ps_to_cycles(ALL_BANK_CLOSE_TIME_PS);
  localparam cnt_t SINGLE_BANK_CLOSE_CYC =
    ps_to_cycles(SINGLE_BANK_CLOSE_TIME_PS);
  localparam cnt_t ROW_ACTIVE_MIN_CYC = ps_to_cycles(ROW_ACTIVE_MIN_TIME_PS);
  localparam cnt_t READ_TO_CLOSE_CYC = ps_to_cycles(READ_TO_CLOSE_TIME_PS);
  localparam cnt_t WRITE_RECOVERY_CYC = ps_to_cycles(WRITE_RECOVERY_TIME_PS);
  localparam cnt_t ACT_TO_COLUMN_CYC =
    ps_to_cycles(ACTIVATE_TO_COLUMN_DELAY_PS);
  localparam cnt_t ROW_CYCLE_CYC = ps_to_cycles(ROW_CYCLE_TIME_PS);
  localparam cnt_t WRITE_LATENCY_CYC = 8'h06;
  localparam cnt_t HALF_BURST_16 = 8'h08;
  localparam cnt_t HALF_BURST_32 = 8'h10;
  localparam cnt_t READ_CLOSE_OFFSET = 8'h08;
  localparam cnt_t WRITE_CLOSE_ADDER = 8'h01;

  // ==========================================================
  // Controller register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CTRL_BL32_BIT = 0;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_FLAG_BIT = 3;
  localparam int CMD_BANK_LSB = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_VIEW_LSB = 8;
  localparam int ST_DEV_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic cnt_t max2(cnt_t a, cnt_t b);
    return (a > b) ? a : b;
  endfunction

  function automatic cnt_t half_burst(logic bl32);
    return bl32 ? HALF_BURST_32 : HALF_BURST_16;
  endfunction

  // Read close point: half burst at least, timer begins half burst - 8
  function automatic cnt_t read_close_delay(logic bl32);
    cnt_t h;
    h = half_burst(bl32);
    return max2(h, cnt_t'(h - READ_CLOSE_OFFSET + READ_TO_CLOSE_CYC));
  endfunction

  function automatic cnt_t write_close_delay(logic bl32);
    return cnt_t'(WRITE_LATENCY_CYC + half_burst(bl32) + WRITE_CLOSE_ADDER
      + WRITE_RECOVERY_CYC);
  endfunction

endpackage

// ### close_link_if.sv
// Command/address link between the close controller and the DRAM model
`timescale 1ns/10ps
interface close_link_if (
  input wire logic aclk
);
  // Chip select marks the first of the two command cycles
  logic cs;
  logic [5:0] command_address_bus;
  logic bl32;
  logic [7:0] bank_open;

  modport ctrl (
    output cs,
    output command_address_bus,
    output bl32,
    input bank_open
  );

  modport dram (
    input cs,
    input command_address_bus,
    input bl32,
    output bank_open
  );
endinterface

// ### bank_close_device.sv
// Device end: bank close decoding, auto-close scheduling and row lockout
`timescale 1ns/10ps
module bank_close_device
  import close_timing_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link
  close_link_if.dram link,
  // User side
  input wire logic clear_illegal,
  output logic [7:0] auto_close_q,
  output logic illegal_q
);

  // ==========================================================
  // First command cycle capture
  logic first_q;
  cmd_op_t op_q;
  logic all_bank_flag_q;
  logic [2:0] bank;
  logic second;
  logic is_col;
  logic [7:0] open_q;
  logic [7:0] bad_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_q <= 1'b0;
      op_q <= OP_NONE;
      all_bank_flag_q <= 1'b0;
    end else begin
      first_q <= link.cs;
      if (link.cs) begin
        op_q <= cmd_op_t'(link.command_address_bus[OP_LSB +: 3]);
        all_bank_flag_q <= link.command_address_bus[FLAG_BIT];
      end
    end
  end

  assign second = first_q && !link.cs;
  assign bank = link.command_address_bus[BANK_LSB +: 3];
  assign is_col = (op_q == OP_RD) || (op_q == OP_WR) || (op_q == OP_MWR);
  assign link.bank_open = open_q;

  // ==========================================================
  // Per-bank state
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic act_hit;
    logic pre_hit;
    logic col_hit;
    logic fire;
    logic pend_q;
    cnt_t delay_q;
    cnt_t ras_q;

    assign act_hit = second && (op_q == OP_ACT) && (bank == 3'(b));
    // Flag high closes every bank and ignores the bank bits
    assign pre_hit = second && (op_q == OP_PRE)
      && (all_bank_flag_q || (bank == 3'(b)));
    assign col_hit = second && is_col && (bank == 3'(b));
    // Lockout holds the internal close until the row was open long enough
    assign fire = pend_q && (delay_q == 8'h00)
      && (ras_q >= ROW_ACTIVE_MIN_CYC);
    assign bad_hit[b] = (col_hit && !open_q[b]) || (act_hit && open_q[b]);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ras_q <= 8'h00;
      end else if (act_hit) begin
        ras_q <= 8'h02;
      end else if (ras_q != 8'hFF) begin
        ras_q <= ras_q + 8'h01;
      end
    end

    // Decode happens one cycle after the command, hence the minus one
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pend_q <= 1'b0;
        delay_q <= 8'h00;
      end else if (col_hit && all_bank_flag_q && open_q[b]) begin
        pend_q <= 1'b1;
        if (op_q == OP_RD) begin
          delay_q <= read_close_delay(link.bl32) - 8'h01;
        end else begin
          delay_q <= write_close_delay(link.bl32) - 8'h01;
        end
      end else if (fire || pre_hit) begin
        pend_q <= 1'b0;
      end else if (pend_q && (delay_q != 8'h00)) begin
        delay_q <= delay_q - 8'h01;
      end
    end

    // Without the flag the bank simply stays open after the burst
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        open_q[b] <= 1'b0;
        auto_close_q[b] <= 1'b0;
      end else begin
        auto_close_q[b] <= fire;
        if (act_hit) begin
          open_q[b] <= 1'b1;
        end else if (pre_hit || fire) begin
          open_q[b] <= 1'b0;
        end
      end
    end
  end

  // Sticky report of column to closed bank or activate to open bank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      illegal_q <= 1'b0;
    end else if (|bad_hit) begin
      illegal_q <= 1'b1;
    end else if (clear_illegal) begin
      illegal_q <= 1'b0;
    end
  end

endmodule // bank_close_device

// ### close_cmd_ctrl.sv
// Controller end: AXI4-Lite command port, per-bank spacing and issue
`timescale 1ns/10ps
module close_cmd_ctrl
  import close_timing_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Link
  close_link_if.ctrl link
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_CHECK = 2'b01,
    S_CA1 = 2'b10,
    S_CA2 = 2'b11
  } state_t;

  state_t state_q;
  logic aw_ok_q;
  logic w_ok_q;
  logic [3:0] waddr_q;
  logic [31:0] wdata_q;
  logic wlane_q;
  logic do_write;
  logic cmd_wr;
  logic mapped_w;
  logic bl32_q;
  logic err_q;
  cmd_op_t op_q;
  logic flag_q;
  logic [2:0] bank_q;
  logic legal;
  logic ready;
  logic issue;
  logic [7:0] open_q;
  logic [7:0] pre_busy;
  cnt_t act_wait_q [NUM_BANKS];
  cnt_t pre_wait_q [NUM_BANKS];
  cnt_t col_wait_q [NUM_BANKS];
  logic cs_q;
  logic [5:0] ca_q;

  // ==========================================================
  // AXI4-Lite slave
  assign awready = !aw_ok_q && !bvalid;
  assign wready = !w_ok_q && !bvalid;
  assign arready = !rvalid;
  assign do_write = aw_ok_q && w_ok_q && !bvalid;
  assign mapped_w = (waddr_q == REG_CTRL) || (waddr_q == REG_CMD)
    || (waddr_q == REG_STATUS);
  // A command written while one is in flight is refused
  assign cmd_wr = do_write && (waddr_q == REG_CMD) && wlane_q
    && (state_q == S_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      waddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wlane_q <= 1'b0;
    end else if (do_write) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_ok_q <= 1'b1;
        waddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_ok_q <= 1'b1;
        wdata_q <= wdata;
        wlane_q <= wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= (mapped_w && !(waddr_q == REG_CMD && state_q != S_IDLE))
        ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
      case (araddr)
        REG_CTRL: rdata[CTRL_BL32_BIT] <= bl32_q;
        REG_CMD: rdata[7:0] <= {1'b0, bank_q, flag_q, op_q};
        REG_STATUS: begin
          rdata[ST_BUSY_BIT] <= (state_q != S_IDLE);
          rdata[ST_ERR_BIT] <= err_q;
          rdata[ST_VIEW_LSB +: 8] <= open_q;
          rdata[ST_DEV_LSB +: 8] <= link.bank_open;
        end
        default: rresp <= RESP_SLVERR;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Configuration and error flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bl32_q <= 1'b0;
    end else if (do_write && waddr_q == REG_CTRL && wlane_q) begin
      bl32_q <= wdata_q[CTRL_BL32_BIT];
    end
  end

  // Set by a command that fails the legality check; the set wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= 1'b0;
    end else if (state_q == S_CHECK && !legal) begin
      err_q <= 1'b1;
    end else if (do_write && waddr_q == REG_STATUS && wlane_q
      && wdata_q[ST_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_q <= OP_NONE;
      flag_q <= 1'b0;
      bank_q <= 3'h0;
    end else if (cmd_wr) begin
      op_q <= cmd_op_t'(wdata_q[CMD_OP_LSB +: 3]);
      flag_q <= wdata_q[CMD_FLAG_BIT];
      bank_q <= wdata_q[CMD_BANK_LSB +: 3];
    end
  end

  // ==========================================================
  // Spacing check against the per-bank counters
  always_comb begin
    legal = 1'b1;
    ready = 1'b0;
    case (op_q)
      OP_ACT: begin
        legal = !open_q[bank_q];
        ready = (act_wait_q[bank_q] == 8'h00);
      end
      OP_RD, OP_WR, OP_MWR: begin
        legal = open_q[bank_q];
        ready = (col_wait_q[bank_q] == 8'h00);
      end
      OP_PRE: begin
        ready = flag_q ? !(|(open_q & pre_busy))
          : !pre_busy[bank_q];
      end
      default: legal = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: if (cmd_wr) state_q <= S_CHECK;
        S_CHECK: begin
          if (!legal) state_q <= S_IDLE;
          else if (ready) state_q <= S_CA1;
        end
        S_CA1: state_q <= S_CA2;
        S_CA2: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Two-cycle command: flag and opcode, then bank bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_q <= 1'b0;
      ca_q <= 6'h00;
    end else if (state_q == S_CHECK && legal && ready) begin
      cs_q <= 1'b1;
      ca_q <= {flag_q, 2'b00, op_q};
    end else if (state_q == S_CA1) begin
      cs_q <= 1'b0;
      ca_q <= {3'b000, bank_q};
    end else begin
      cs_q <= 1'b0;
      ca_q <= 6'h00;
    end
  end

  assign link.cs = cs_q;
  assign link.command_address_bus = ca_q;
  assign link.bl32 = bl32_q;
  assign issue = (state_q == S_CA1);

  // ==========================================================
  // Per-bank open state and countdowns, counted from the issue edge
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic hit;
    logic pre_hit;
    cnt_t act_dec;
    cnt_t pre_dec;
    cnt_t col_dec;
    cnt_t ap_start;

    assign hit = issue && (bank_q == 3'(b));
    assign pre_hit = issue && (op_q == OP_PRE) && (flag_q || hit);
    assign act_dec = (act_wait_q[b] == 8'h00) ? 8'h00 : act_wait_q[b] - 8'h01;
    assign pre_dec = (pre_wait_q[b] == 8'h00) ? 8'h00 : pre_wait_q[b] - 8'h01;
    assign col_dec = (col_wait_q[b] == 8'h00) ? 8'h00 : col_wait_q[b] - 8'h01;
    assign pre_busy[b] = (pre_wait_q[b] != 8'h00);
    // Internal read close waits for both its delay and the row lockout
    assign ap_start = max2(read_close_delay(bl32_q), pre_dec);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        open_q[b] <= 1'b0;
        act_wait_q[b] <= 8'h00;
        pre_wait_q[b] <= 8'h00;
        col_wait_q[b] <= 8'h00;
      end else begin
        open_q[b] <= open_q[b];
        act_wait_q[b] <= act_dec;
        pre_wait_q[b] <= pre_dec;
        col_wait_q[b] <= col_dec;
        if (hit && op_q == OP_ACT) begin
          open_q[b] <= 1'b1;
          act_wait_q[b] <= max2(act_dec, ROW_CYCLE_CYC);
          pre_wait_q[b] <= max2(pre_dec, ROW_ACTIVE_MIN_CYC);
          col_wait_q[b] <= ACT_TO_COLUMN_CYC;
        end else if (hit && op_q == OP_RD) begin
          pre_wait_q[b] <= max2(pre_dec, read_close_delay(bl32_q));
          if (flag_q) begin
            open_q[b] <= 1'b0;
            act_wait_q[b] <= max2(act_dec,
              cnt_t'(ap_start + SINGLE_BANK_CLOSE_CYC));
          end
        end else if (hit && (op_q == OP_WR || op_q == OP_MWR)) begin
          pre_wait_q[b] <= max2(pre_dec, write_close_delay(bl32_q));
          if (flag_q) begin
            open_q[b] <= 1'b0;
            act_wait_q[b] <= max2(act_dec, cnt_t'(max2(pre_dec,
              write_close_delay(bl32_q)) + SINGLE_BANK_CLOSE_CYC));
          end
        end else if (pre_hit) begin
          open_q[b] <= 1'b0;
          // Latest close sets the period; all-bank uses the longer time
          act_wait_q[b] <= max2(act_dec, flag_q ? ALL_BANK_CLOSE_CYC
            : SINGLE_BANK_CLOSE_CYC);
        end
      end
    end
  end

endmodule // close_cmd_ctrl

// ### close_link_checker.sv
// Assertions on the bank close link between controller and device
`timescale 1ns/10ps
module close_link_checker
  import close_timing_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link
  input wire logic cs,
  input wire logic [5:0] command_address_bus,
  input wire logic bl32,
  input wire logic [7:0] bank_open,
  // Device outputs
  input wire logic [7:0] auto_close_q,
  input wire logic illegal_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic cs_d, flag_q, col, early, late;
  logic [2:0] op_q, bank_q, bank;
  logic [7:0] ac_q, half, ap_q;
  logic [7:0] age_q [8];
  logic [7:0] need_q [8];
  assign bank = command_address_bus[2:0];
  assign col = cs_d && op_q inside {OP_RD, OP_WR, OP_MWR};
  assign half = bl32 ? HALF_BURST_32 : HALF_BURST_16;
  // ==========================================================
  // Per-bank age since the last column command, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_d <= 1'b0;
      ap_q <= 8'h00;
      ac_q <= 8'h00;
      for (int b = 0; b < 8; b++) begin
        age_q[b] <= 8'h00;
      end
    end else begin
      cs_d <= cs;
      if (cs) begin
        op_q <= command_address_bus[2:0];
        flag_q <= command_address_bus[FLAG_BIT];
      end
      if (cs_d) begin
        bank_q <= bank;
      end
      if (auto_close_q != 8'h00) begin
        ac_q <= auto_close_q;
      end
      for (int b = 0; b < 8; b++) begin
        if (col && bank == 3'(b)) begin
          age_q[b] <= 8'h01;
          ap_q[b] <= flag_q;
          need_q[b] <= (op_q == OP_RD) ? half :
            8'(WRITE_LATENCY_CYC + half + 8'h01 + WRITE_RECOVERY_CYC);
        end else begin
          if (age_q[b] != 8'h00 && age_q[b] != 8'hFF) begin
            age_q[b] <= age_q[b] + 8'h01;
          end
          if (auto_close_q[b]) begin
            ap_q[b] <= 1'b0;
          end
        end
      end
    end
  end
  // Early pulse also catches a close that nobody asked for
  always_comb begin
    early = 1'b0;
    late = 1'b0;
    for (int b = 0; b < 8; b++) begin
      if (auto_close_q[b] && !(ap_q[b] && age_q[b] >= need_q[b])) begin
        early = 1'b1;
      end
      if (ap_q[b] && age_q[b] > need_q[b] + 8'h06) begin
        late = 1'b1;
      end
    end
  end
  // ==========================================================
  // Properties
  AST_CS_GAP: assert property (cs |=> !cs [*3])
    else $error("Command strobes closer than four cycles");
  AST_CA1_FORM: assert property (cs |->
    command_address_bus[4:3] == 2'h0
    && command_address_bus[2:0] inside {[3'h1:3'h5]})
    else $error("Malformed first command cycle");
  AST_CA2_FORM: assert property (cs |=>
    command_address_bus[5:3] == 3'h0 ##1 command_address_bus == 6'h00)
    else $error("Malformed second command cycle");
  AST_PRE_ALL: assert property (cs && bank == OP_PRE
    && command_address_bus[FLAG_BIT] |-> ##[2:3] bank_open == 8'h00)
    else $error("All-bank close left a bank open");
  AST_PRE_ONE: assert property (cs_d && op_q == OP_PRE && !flag_q
    |=> ##[0:1] !bank_open[bank_q])
    else $error("Single-bank close left its bank open");
  AST_PRE_SPACE: assert property (cs_d && op_q == OP_PRE
    && !flag_q && age_q[bank] != 8'h00 |-> age_q[bank] >= need_q[bank])
    else $error("Close issued too soon after a column command");
  AST_AUTO_EARLY: assert property (!early)
    else $error("Automatic close too early or unrequested");
  AST_AUTO_LATE: assert property (!late)
    else $error("Automatic close overdue");
  AST_AUTO_SHUT: assert property (auto_close_q != 8'h00
    |=> ##[0:1] (bank_open & ac_q) == 8'h00)
    else $error("Bank still open after automatic close");
  AST_NO_ILLEGAL: assert property (!illegal_q)
    else $error("Controller issued an illegal command");
endmodule // close_link_checker

// ### bank_precharge_timing_tb.sv
// Self-checking bench for the bank close controller and device
`timescale 1ns/10ps
module bank_precharge_timing_tb
  import close_timing_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, ill, ill2, clr, clr2;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, r;
  logic [7:0] ac, ac2, exp_open;
  logic [2:0] b, b2;
  int bad_count, num_checks, cyc;
  // ==========================================================
  // Both ends, the checker, and a second device driven directly
  close_link_if link (.aclk(aclk));
  close_link_if link2 (.aclk(aclk));
  close_cmd_ctrl u_close_cmd_ctrl (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .link(link));
  bank_close_device u_bank_close_device (.aclk(aclk), .aresetn(aresetn),
    .link(link), .clear_illegal(clr), .auto_close_q(ac), .illegal_q(ill));
  bank_close_device u_bank_close_device_2 (.aclk(aclk),
    .aresetn(aresetn), .link(link2), .clear_illegal(clr2),
    .auto_close_q(ac2), .illegal_q(ill2));
  close_link_checker u_close_link_checker (.aclk(aclk),
    .aresetn(aresetn), .cs(link.cs),
    .command_address_bus(link.command_address_bus), .bl32(link.bl32),
    .bank_open(link.bank_open), .auto_close_q(ac), .illegal_q(ill));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Generous ceiling: the whole sequence needs under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Signals change just after a rising edge; an answer is taken at the
  // rising edge at which its valid is sampled high
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      ta = awready && awvalid;
      tw = wready && wvalid;
      tb = bvalid;
      rs = bresp;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] rs);
    logic ta, tb;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      ta = arready && arvalid;
      tb = rvalid;
      d = rdata;
      rs = rresp;
      if (ta) arvalid <= 1'b0;
    end while (!tb);
    rready <= 1'b0;
  endtask
  task automatic settle();
    int n;
    n = 0;
    do begin
      axi_rd(REG_STATUS, v, r);
      n++;
    end while ((v[0] !== 1'b0 || v[23:16] !== exp_open) && n < 50);
    check(32'(v[23:16]), 32'(exp_open));
    check(32'(v[15:8]), 32'(exp_open));
  endtask
  task automatic cmd(input cmd_op_t op, input logic f, input logic [2:0] k);
    axi_wr(REG_CMD, {25'h0, k, f, op}, 4'hF, r);
    check(32'(r), 32'(RESP_OKAY));
    if (op == OP_ACT) exp_open[k] = 1'b1;
    else if (op == OP_PRE && f) exp_open = 8'h00;
    else if (op == OP_PRE || f) exp_open[k] = 1'b0;
    settle();
  endtask
  task automatic raw(input logic [5:0] c1, input logic [5:0] c2);
    @(posedge aclk);
    link2.cs <= 1'b1;
    link2.command_address_bus <= c1;
    @(posedge aclk);
    link2.cs <= 1'b0;
    link2.command_address_bus <= c2;
    @(posedge aclk);
    link2.command_address_bus <= 6'h00;
    repeat (4) @(posedge aclk);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, clr, clr2} = 8'h00;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    link2.cs = 1'b0;
    link2.command_address_bus = 6'h00;
    link2.bl32 = 1'b0;
    bad_count = 0;
    num_checks = 0;
    cyc = 0;
    exp_open = 8'h00;
    b = 3'($urandom(32'h9228));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(REG_CTRL, v, r);
    check(v, 32'h0);
    axi_rd(REG_STATUS, v, r);
    check(v, 32'h0);
    axi_rd(4'hC, v, r);
    check({30'h0, r}, 32'(RESP_SLVERR));
    axi_wr(4'hC, 32'h1, 4'hF, r);
    check({30'h0, r}, 32'(RESP_SLVERR));
    axi_wr(REG_CTRL, 32'h1, 4'h0, r);
    axi_rd(REG_CTRL, v, r);
    check(v, 32'h0);
    for (int k = 0; k < 2; k++) begin
      axi_wr(REG_CTRL, 32'(k), 4'hF, r);
      check(32'(link.bl32), 32'(k));
      b = 3'($urandom_range(7, 0));
      b2 = b ^ 3'h5;
      cmd(OP_ACT, 1'b0, b);
      cmd(OP_ACT, 1'b0, b2);
      cmd(OP_WR, 1'b0, b);
      cmd(OP_RD, 1'b0, b2);
      cmd(OP_MWR, 1'b0, b);
      cmd(OP_PRE, 1'b0, b);
      cmd(OP_RD, 1'b1, b2);
      cmd(OP_ACT, 1'b0, b);
      cmd(OP_WR, 1'b1, b);
      cmd(OP_ACT, 1'b0, b);
      cmd(OP_MWR, 1'b1, b);
      cmd(OP_ACT, 1'b0, b);
      cmd(OP_RD, 1'b0, b);
      cmd(OP_PRE, 1'b0, b);
      for (int i = 0; i < 8; i++) begin
        cmd(OP_ACT, 1'b0, 3'(i));
      end
      cmd(OP_PRE, 1'b1, 3'($urandom_range(7, 0)));
    end
    // A command written while the close still waits is refused
    cmd(OP_ACT, 1'b0, 3'h0);
    cmd(OP_WR, 1'b0, 3'h0);
    axi_wr(REG_CMD, {25'h0, 3'h0, 1'b0, OP_PRE}, 4'hF, r);
    check({30'h0, r}, 32'(RESP_OKAY));
    axi_wr(REG_CMD, {25'h0, 3'h1, 1'b0, OP_ACT}, 4'hF, r);
    check({30'h0, r}, 32'(RESP_SLVERR));
    exp_open[0] = 1'b0;
    settle();
    // An undefined opcode is refused and raises the error flag
    axi_wr(REG_CMD, 32'h0000_0007, 4'hF, r);
    axi_rd(REG_STATUS, v, r);
    check(v, 32'h0000_0002);
    axi_rd(REG_CMD, v, r);
    check(v, 32'h0000_0007);
    axi_wr(REG_STATUS, 32'h0000_0002, 4'hF, r);
    axi_rd(REG_STATUS, v, r);
    check(v, 32'h0000_0000);
    raw({3'h0, OP_RD}, 6'h03);
    check(32'(ill2), 32'h1);
    raw({3'h0, OP_ACT}, 6'h03);
    raw({3'h0, OP_ACT}, 6'h05);
    raw({3'h0, OP_PRE}, 6'h03);
    check(32'(link2.bank_open), 32'h20);
    // Auto-close read of bank 5 with a 16-word burst fires eight edges on
    raw({3'h4, OP_RD}, 6'h05);
    repeat (5) @(posedge aclk);
    check(32'(ac2), 32'h20);
    raw({3'h4, OP_PRE}, 6'h02);
    check(32'(link2.bank_open), 32'h00);
    clr2 <= 1'b1;
    @(posedge aclk);
    clr2 <= 1'b0;
    @(posedge aclk);
    check(32'(ill2), 32'h0);
    give_verdict();
  end
endmodule // bank_precharge_timing_tb
